// file: logic/smrc_core.sv
// Four-lane multiplier, component addressing and activity-mask stack
//
// Summary of operation
// (RULE1) Every lane owns a multiplier loaded from the M bus on two inputs.
// (RULE2) 32-bit product splits into high and low 16-bit halves on the A bus.
// (RULE3) Product readable one cycle after second operand; sequencer waits a cycle. Here the product lands two cycles after it; the bench issues two nops.
// (RULE4) Shift modifier: coefficient 0, component 2, opacity 3 bits left.
// (RULE5) Per-operand qualifier chooses unsigned or two's-complement signed.
// (RULE6) No modifier means unsigned, zero shift, coefficient format.
// (RULE7) Bits shifted past operand top are dropped silently.
// (RULE8) Component access moves one channel of four pixels, one per lane.
// (RULE9) Channel defaults to red (0); selector 1 picks green.
// (RULE10) Component access succeeds only when named index register holds 16.
// (RULE11) Pixel is four words; advance of 16 words moves four pixels.
// (RULE12) Lane registers replicated; base and index registers single and shared.
// (RULE13) Lane-to-scalar move takes named lane; inactive lane leaves scalar unchanged.
// (RULE14) Force pushes a 4-bit mask, becoming current mask.
// (RULE15) Instruction mask ANDs with current mask for one instruction only.
// (RULE16) Instruction mask can only clear lanes, never enable them.
// (RULE17) Pop discards forced mask, restoring previous; software pairs them.
// (RULE18) Mask has one bit per lane; clear bit suppresses that lane.
// (RULE19) No lane-to-lane path; data crosses through a shared scalar register.
// (RULE20) Product registers hold until next operand pair completes.
// (RULE21) Stack keeps pushed levels above an all-active base mask.
`timescale 1ns/100ps
module smrc_core
  import smrc_pkg::*;
#(
  parameter int STACK_DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sequencer micro-operations
  input wire logic op_valid,
  input wire logic op_mult_x,
  input wire logic op_mult_y,
  input wire logic [1:0] op_shift_mode,
  input wire logic op_signed,
  input wire logic [4*WORD_W-1:0] mbus_data,
  input wire logic op_force,
  input wire logic op_pop,
  input wire logic [3:0] op_force_mask,
  input wire logic op_inst_mask_en,
  input wire logic [3:0] op_inst_mask,
  input wire logic op_to_scalar,
  input wire logic [1:0] op_src_lane,
  input wire logic [4*WORD_W-1:0] lane_regs,
  input wire logic op_comp_rd,
  input wire logic op_comp_wr,
  input wire logic op_chan_given,
  input wire logic [1:0] op_chan,
  input wire logic op_base_step,
  // A bus products, one 16-bit word per lane
  output logic [4*WORD_W-1:0] abus_hi,
  output logic [4*WORD_W-1:0] abus_lo,
  // Effective activity mask for the current instruction
  output logic [3:0] lane_active,
  // Component-mode scratchpad access and scalar register output
  output logic comp_go,
  output logic comp_we,
  output logic [4*WORD_W-1:0] comp_addr,
  output logic comp_fault,
  output logic [WORD_W-1:0] scalar_out
);
  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16) $error("smrc_core: bad STACK_DEPTH");
  end

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [STACK_DEPTH-1:0][3:0] stk;
    logic [3:0] sp;
    logic [WORD_W-1:0] base;
    logic [WORD_W-1:0] index;
    logic [WORD_W-1:0] scalar;
    logic comp_go;
    logic comp_we;
    logic comp_fault;
    logic [4*WORD_W-1:0] comp_addr;
    logic ovf;
    logic unf;
    logic ack;
    logic [31:0] rdat;
  } smrc_state_t;

  smrc_state_t s_q, s_d;

  logic [3:0] cur_mask;
  logic [3:0] eff_mask;
  logic [LANES-1:0] lane_busy;
  logic wb_req;

  assign cur_mask = s_q.stk[s_q.sp];
  assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;

  // Instruction mask can only narrow the stacked mask
  always_comb begin
    eff_mask = cur_mask;
    if (op_inst_mask_en) begin
      eff_mask = cur_mask & op_inst_mask; // RULE15 RULE16
    end
  end

  assign lane_active = eff_mask; // RULE18

  // ********************************************************
  // Lane multipliers
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gen_lane
      // RULE12 RULE19
      smrc_lane_mul #(.W(WORD_W)) u_mul (
        .clk(clk),
        .reset(reset),
        .ld_x(op_valid && op_mult_x),
        .ld_y(op_valid && op_mult_y),
        .din(mbus_data[g*WORD_W +: WORD_W]),
        .shm(op_shift_mode),
        .sgn(op_signed),
        .run(eff_mask[g]),
        .prod_hi(abus_hi[g*WORD_W +: WORD_W]),
        .prod_lo(abus_lo[g*WORD_W +: WORD_W]),
        .busy(lane_busy[g])
      );
    end
  endgenerate

  function automatic logic [WORD_W-1:0] lane_word(input logic [4*WORD_W-1:0] v,
                                                  input logic [1:0] i);
    lane_word = v[i*WORD_W +: WORD_W];
  endfunction

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      wb_merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic [1:0] chan;
    logic [31:0] wv;
    chan = CHAN_RED;
    wv = '0;
    s_d = s_q;
    s_d.comp_go = 1'b0;
    s_d.comp_we = 1'b0;
    s_d.ack = 1'b0;

    if (op_valid) begin
      // Stack
      if (op_force) begin
        if (s_q.sp < 4'(STACK_DEPTH - 1)) begin
          s_d.sp = s_q.sp + 4'h1;
          s_d.stk[s_q.sp + 4'h1] = op_force_mask; // RULE14
        end else begin
          s_d.ovf = 1'b1;
        end
      end else if (op_pop) begin
        if (s_q.sp != 4'h0) begin
          s_d.sp = s_q.sp - 4'h1; // RULE17 RULE21
        end else begin
          s_d.unf = 1'b1;
        end
      end

      // Lane to scalar transfer
      if (op_to_scalar && eff_mask[op_src_lane]) begin
        s_d.scalar = lane_word(lane_regs, op_src_lane); // RULE13 RULE19
      end

      // Component addressing
      if (op_comp_rd || op_comp_wr) begin
        chan = op_chan_given ? op_chan : CHAN_RED; // RULE9
        if (s_q.index == COMP_INDEX_OK) begin // RULE10
          s_d.comp_go = 1'b1;
          s_d.comp_we = op_comp_wr;
          for (int l = 0; l < LANES; l++) begin
            s_d.comp_addr[l*WORD_W +: WORD_W] =
              s_q.base + WORD_W'(l * PIXEL_WORDS) + WORD_W'(chan); // RULE8 RULE11
          end
          if (op_base_step) begin
            s_d.base = s_q.base + s_q.index; // RULE11
          end
        end else begin
          s_d.comp_fault = 1'b1;
        end
      end
    end

    // Wishbone slave, answers one cycle after the request
    if (wb_req) begin
      s_d.ack = 1'b1;
      unique case (wb_adr_i)
        REG_CTRL: begin
          s_d.rdat = {30'h0, s_q.unf, s_q.ovf};
          if (wb_we_i) begin
            if (wb_sel_i[0] && wb_dat_i[0]) s_d.ovf = 1'b0;
            if (wb_sel_i[0] && wb_dat_i[1]) s_d.unf = 1'b0;
            if (wb_sel_i[0] && wb_dat_i[2]) s_d.comp_fault = 1'b0;
          end
        end
        REG_MASK: s_d.rdat = {24'h0, s_q.sp, cur_mask};
        REG_STAT: s_d.rdat = {27'h0, |lane_busy, s_q.comp_fault, s_q.unf, s_q.ovf, 1'b0};
        REG_BASE: begin
          s_d.rdat = {16'h0, s_q.base};
          if (wb_we_i) begin
            wv = wb_merge({16'h0, s_q.base}, wb_dat_i, wb_sel_i);
            s_d.base = wv[WORD_W-1:0];
          end
        end
        REG_INDEX: begin
          s_d.rdat = {16'h0, s_q.index};
          if (wb_we_i) begin
            wv = wb_merge({16'h0, s_q.index}, wb_dat_i, wb_sel_i);
            s_d.index = wv[WORD_W-1:0]; // RULE10
          end
        end
        REG_PROD_HI: s_d.rdat = {16'h0, abus_hi[WORD_W-1:0]};
        REG_PROD_LO: s_d.rdat = {16'h0, abus_lo[WORD_W-1:0]};
        REG_SCALAR: s_d.rdat = {16'h0, s_q.scalar};
        default: s_d.rdat = BAD_ADDR_DATA;
      endcase
      // Hardware set wins over a simultaneous software clear
      if (op_valid && op_force && s_q.sp >= 4'(STACK_DEPTH - 1)) s_d.ovf = 1'b1;
      if (op_valid && !op_force && op_pop && s_q.sp == 4'h0) s_d.unf = 1'b1;
      if (op_valid && (op_comp_rd || op_comp_wr) && s_q.index != COMP_INDEX_OK) begin
        s_d.comp_fault = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.stk <= {STACK_DEPTH{MASK_ALL}}; // RULE21
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign comp_go = s_q.comp_go;
  assign comp_we = s_q.comp_we;
  assign comp_addr = s_q.comp_addr;
  assign comp_fault = s_q.comp_fault;
  assign scalar_out = s_q.scalar;
endmodule

// file: logic/smrc_lane_mul.sv
// One lane multiplier with shifted, optionally signed operands
`timescale 1ns/100ps
module smrc_lane_mul
  import smrc_pkg::*;
#(
  parameter int W = WORD_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ld_x,
  input wire logic ld_y,
  input wire logic [W-1:0] din,
  input wire logic [1:0] shm,
  input wire logic sgn,
  input wire logic run,
  output logic [W-1:0] prod_hi,
  output logic [W-1:0] prod_lo,
  output logic busy
);
  initial begin
    if (W < 4) $error("smrc_lane_mul: W too small");
  end

  typedef struct packed {
    logic [W-1:0] x;
    logic xs;
    logic [W-1:0] y;
    logic ys;
    logic xv;
    logic yv;
    logic go;
    logic [W-1:0] hi;
    logic [W-1:0] lo;
  } smrc_lane_t;

  smrc_lane_t s_q, s_d;

  function automatic logic [W-1:0] shift_op(input logic [W-1:0] v, input logic [1:0] m);
    logic [1:0] n;
    n = (m == SHM_COMP) ? SHIFT_COMP : (m == SHM_ALPHA) ? SHIFT_ALPHA : SHIFT_COEFF;
    shift_op = v << n; // Top bits fall off silently
  endfunction

  function automatic logic [2*W:0] ext(input logic [W-1:0] v, input logic s);
    ext = s ? {{(W+1){v[W-1]}}, v} : {{(W+1){1'b0}}, v};
  endfunction

  logic [2*W:0] full;
  assign full = ext(s_q.x, s_q.xs) * ext(s_q.y, s_q.ys);

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    if (run && ld_x) begin
      s_d.x = shift_op(din, shm); // RULE1 RULE4 RULE7
      s_d.xs = sgn; // RULE5 RULE6
      s_d.xv = 1'b1;
    end
    if (run && ld_y) begin
      s_d.y = shift_op(din, shm); // RULE1 RULE4 RULE7
      s_d.ys = sgn; // RULE5 RULE6
      s_d.yv = 1'b1;
    end
    if (s_d.xv && s_d.yv && run && (ld_x || ld_y)) begin
      s_d.go = 1'b1;
      s_d.xv = 1'b0;
      s_d.yv = 1'b0;
    end
    if (s_q.go) begin
      s_d.hi = full[2*W-1:W]; // RULE2 RULE3 RULE20
      s_d.lo = full[W-1:0]; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prod_hi = s_q.hi;
  assign prod_lo = s_q.lo;
  assign busy = s_q.go;
endmodule

// file: logic/smrc_pkg.sv
// Package: constants and types for the four-lane multiplier and activity-mask block
package smrc_pkg;
  localparam int LANES = 4;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;

  // Shift modifier codes and amounts
  localparam logic [1:0] SHM_COEFF = 2'h0;
  localparam logic [1:0] SHM_COMP = 2'h1;
  localparam logic [1:0] SHM_ALPHA = 2'h2;
  localparam logic [1:0] SHIFT_COEFF = 2'h0;
  localparam logic [1:0] SHIFT_COMP = 2'h2;
  localparam logic [1:0] SHIFT_ALPHA = 2'h3;

  // Component addressing
  localparam logic [15:0] COMP_INDEX_OK = 16'h0010;
  localparam int PIXEL_WORDS = 4;
  localparam logic [1:0] CHAN_RED = 2'h0;

  // Activity mask
  localparam logic [3:0] MASK_ALL = 4'hf;

  // Wishbone register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_BASE = 8'h0c;
  localparam logic [7:0] REG_INDEX = 8'h10;
  localparam logic [7:0] REG_PROD_HI = 8'h14;
  localparam logic [7:0] REG_PROD_LO = 8'h18;
  localparam logic [7:0] REG_SCALAR = 8'h1c;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;

  typedef enum logic [2:0] {
    SMRC_IDLE = 3'b001,
    SMRC_MUL = 3'b010,
    SMRC_DONE = 3'b100
  } smrc_mstate_t;
endpackage

// file: verif/smrc_core_tb.sv
// Self-checking bench for smrc_core with a sequencer model
`timescale 1ns/100ps
module smrc_core_tb
  import smrc_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, op_valid, op_mult_x, op_mult_y, op_signed, op_force, op_pop;
  logic op_inst_mask_en, op_to_scalar, op_comp_rd, op_comp_wr, op_chan_given, op_base_step;
  logic comp_go, comp_we, comp_fault;
  logic [1:0] op_shift_mode, op_src_lane, op_chan;
  logic [3:0] op_force_mask, op_inst_mask, lane_active;
  logic [63:0] mbus_data, lane_regs, abus_hi, abus_lo, comp_addr;
  logic [15:0] scalar_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  smrc_core i_smrc_core (.*);
  smrc_seq i_smrc_seq (.*);
  always #5 clk = ~clk;
  // ********
  // Helpers
  // ********
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [71:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic op(input int k, input logic [63:0] d, input logic [3:0] a);
    i_smrc_seq.issue(k, d, a);
  endtask
  function automatic logic [31:0] prod_exp(input logic [15:0] x, y, input logic [3:0] a);
    logic [15:0] u, v;
    logic [1:0] s;
    s = a[1:0] == 2'h1 ? 2'h2 : (a[1:0] == 2'h2 ? 2'h3 : 2'h0);
    u = x << s;
    v = y << s;
    return (a[2] ? {{16{u[15]}}, u} : {16'h0, u}) * (a[2] ? {{16{v[15]}}, v} : {16'h0, v});
  endfunction
  // ********
  // Scenarios
  // ********
  task automatic t_mask;
    logic [31:0] q;
    op(3, 0, 4'h5);
    op(5, 0, 4'h3);
    #1 chk("and", lane_active, 4'h1);
    op(0, 0, 4'h0);
    #1 chk("after", lane_active, 4'h5);
    op(5, 0, 4'ha);
    #1 chk("no enable", lane_active, 4'h0);
    op(3, 0, 4'h2);
    op(0, 0, 4'h0);
    #1 chk("force", lane_active, 4'h2);
    op(4, 0, 4'h0);
    op(0, 0, 4'h0);
    #1 chk("pop", lane_active, 4'h5);
    op(4, 0, 4'h0);
    op(0, 0, 4'h0);
    wb(1'b0, REG_MASK, 0, q);
    chk("base", q[7:0], 8'h0f);
    op(4, 0, 4'h0);
    op(0, 0, 4'h0);
    wb(1'b0, REG_CTRL, 0, q);
    chk("underflow", q[1:0], 2'b10);
    wb(1'b0, REG_MASK, 0, q);
    chk("base kept", q[7:0], 8'h0f);
    wb(1'b1, REG_CTRL, 32'h2, q);
    wb(1'b0, REG_CTRL, 0, q);
    chk("cleared", q[1:0], 2'b00);
  endtask
  task automatic t_scalar;
    logic [31:0] q;
    op(3, 0, 4'hb);
    op(6, 64'h4444_3333_2222_1111, 4'h2);
    op(0, 0, 4'h0);
    #1 chk("idle lane", scalar_out, 16'h0);
    op(6, 64'h4444_3333_2222_1111, 4'h3);
    op(4, 0, 4'h0);
    op(0, 0, 4'h0);
    wb(1'b0, REG_SCALAR, 0, q);
    chk("lane3", q[15:0], 16'h4444);
  endtask
  task automatic t_comp;
    logic [31:0] q;
    wb(1'b1, REG_INDEX, 32'h10, q);
    wb(1'b1, REG_BASE, 32'h40, q);
    op(7, 0, 4'h0);
    op(0, 0, 4'h0);
    #1 chk("red", {comp_go, comp_we, comp_addr}, {2'b10, 64'h004c_0048_0044_0040});
    op(8, 0, 4'h9);
    op(0, 0, 4'h0);
    #1 chk("green", {comp_go, comp_we, comp_addr}, {2'b11, 64'h004d_0049_0045_0041});
    op(10, 0, 4'h0);
    op(7, 0, 4'h0);
    op(0, 0, 4'h0);
    #1 chk("step", comp_addr, 64'h005c_0058_0054_0050);
    wb(1'b1, REG_INDEX, 32'h8, q);
    op(7, 0, 4'h0);
    op(0, 0, 4'h0);
    #1 chk("fault", {comp_go, comp_fault}, 2'b01);
    wb(1'b0, REG_BASE, 0, q);
    chk("base", q[15:0], 16'h0050);
    wb(1'b0, 8'h20, 0, q);
    chk("unmapped", q, BAD_ADDR_DATA);
  endtask
  task automatic t_mul;
    logic [63:0] x, y;
    logic [31:0] p;
    logic [31:0] q;
    x = 64'h8003_0fff_7001_c001;
    y = 64'h0803_1234_ffff_0005;
    for (int a = 0; a < 8; a++) begin
      op(1, x, 4'(a));
      op(2, y, 4'(a));
      op(0, 0, 4'h0);
      op(0, 0, 4'h0);
      #1;
      for (int g = 0; g < 4; g++) begin
        p = prod_exp(x[16*g+:16], y[16*g+:16], 4'(a));
        chk("hi", abus_hi[16*g+:16], p[31:16]);
        chk("lo", abus_lo[16*g+:16], p[15:0]);
      end
    end
    p = prod_exp(x[15:0], y[15:0], 4'h7);
    wb(1'b0, REG_PROD_HI, 0, q);
    chk("rd hi", q, {16'h0, p[31:16]});
    wb(1'b0, REG_PROD_LO, 0, q);
    chk("rd lo", q, {16'h0, p[15:0]});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_mask;
    t_scalar;
    t_comp;
    t_mul;
    wrap_up;
  end
endmodule

// file: verif/smrc_properties.sv
// Concurrent checks on the smrc_core ports
`timescale 1ns/100ps
module smrc_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_ack_o,
  input wire logic op_valid,
  input wire logic op_mult_x,
  input wire logic op_mult_y,
  input wire logic op_force,
  input wire logic op_pop,
  input wire logic [3:0] op_force_mask,
  input wire logic op_inst_mask_en,
  input wire logic [3:0] op_inst_mask,
  input wire logic op_to_scalar,
  input wire logic op_comp_rd,
  input wire logic op_comp_wr,
  input wire logic [63:0] abus_hi,
  input wire logic [3:0] lane_active,
  input wire logic comp_go,
  input wire logic [15:0] scalar_out
);
  // ********
  // Assertions
  // ********
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  wire ld = op_valid && (op_mult_x || op_mult_y);
  wire im = op_valid && op_inst_mask_en;
  wire pp = op_force || op_pop;
  wire ca = op_valid && (op_comp_rd || op_comp_wr);
  sequence calm;
    op_valid && !pp && !op_inst_mask_en;
  endsequence
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_force_top: assert property (op_valid && op_force ##1 !im |-> lane_active == $past(op_force_mask))
    else $error("forced mask not current");
  chk_inst_clear: assert property (im |-> (lane_active & ~op_inst_mask) == 4'h0)
    else $error("lane enabled by instruction mask");
  chk_inst_once: assert property (
    im && !pp ##1 calm |-> $past(lane_active) == (lane_active & $past(op_inst_mask)))
    else $error("instruction mask changed stack");
  chk_mask_steady: assert property (calm ##1 calm |-> $stable(lane_active))
    else $error("mask moved without push or pop");
  chk_prod_cause: assert property ($changed(abus_hi) |-> $past(ld, 2) || $past(ld, 3))
    else $error("product changed without a load");
  chk_comp_cause: assert property (comp_go |-> $past(ca))
    else $error("component access without request");
  chk_scalar_src: assert property (
    $changed(scalar_out) |-> $past(op_valid && op_to_scalar))
    else $error("scalar changed without a move");
  cover property (ld ##1 ld);
  cover property (comp_go);
  cover property (op_valid && op_force ##1 im);
endmodule
bind smrc_core smrc_properties i_smrc_properties (.clk, .reset, .wb_ack_o, .op_valid, .op_mult_x,
  .op_mult_y, .op_force, .op_pop, .op_force_mask, .op_inst_mask_en, .op_inst_mask, .op_to_scalar,
  .op_comp_rd, .op_comp_wr, .abus_hi, .lane_active, .comp_go, .scalar_out);

// file: verif/smrc_seq.sv
// Sequencer model driving one micro-op per clock
`timescale 1ns/100ps
module smrc_seq (
  input wire logic clk,
  output logic op_valid,
  output logic op_mult_x,
  output logic op_mult_y,
  output logic [1:0] op_shift_mode,
  output logic op_signed,
  output logic [63:0] mbus_data,
  output logic op_force,
  output logic op_pop,
  output logic [3:0] op_force_mask,
  output logic op_inst_mask_en,
  output logic [3:0] op_inst_mask,
  output logic op_to_scalar,
  output logic [1:0] op_src_lane,
  output logic [63:0] lane_regs,
  output logic op_comp_rd,
  output logic op_comp_wr,
  output logic op_chan_given,
  output logic [1:0] op_chan,
  output logic op_base_step
);
  // ********
  // Issue
  // ********
  // Code 10: component read with base step, as the step only acts with an access
  task automatic drive(input int k, input logic [63:0] d, input logic [3:0] a);
    {op_base_step, op_comp_wr, op_comp_rd, op_to_scalar, op_inst_mask_en, op_pop, op_force,
      op_mult_y, op_mult_x} <= 9'((10'h1 << k) >> 1) | ((k == 10) ? 9'h140 : 9'h000);
    {mbus_data, lane_regs} <= {2{d}};
    {op_force_mask, op_inst_mask} <= {2{a}};
    {op_chan_given, op_signed, op_shift_mode} <= a;
    {op_src_lane, op_chan} <= {2{a[1:0]}};
  endtask
  // Only one clock-edge wait here: the caller spaces ops, the two nops after a second operand included
  task automatic issue(input int k, input logic [63:0] d, input logic [3:0] a);
    @(posedge clk);
    op_valid <= 1'b1;
    drive(k, d, a);
  endtask
  initial begin
    op_valid = 1'b0;
    drive(0, '0, '0);
  end
endmodule
